// ===== bldsr_pkg.sv
/*
  Constants and types for the branch, load/store decode and architectural
  state block: opcodes, field positions, status bit positions, reset values.
  Assumes 32-bit instruction words with doc bit 0 as the most significant bit.
*/
`default_nettype none
package bldsr_pkg;

  // ****************************************
  // Major opcodes
  // ****************************************
  localparam logic [5:0] OPC_UNCOND   = 6'h2E;  // 101110
  localparam logic [5:0] OPC_COND     = 6'h2F;  // 101111
  localparam logic [5:0] OPC_SPECIAL  = 6'h25;  // 100101
  localparam logic [5:0] OPC_LD_BYTE  = 6'h30;
  localparam logic [5:0] OPC_LD_HALF  = 6'h31;
  localparam logic [5:0] OPC_LD_WORD  = 6'h32;
  localparam logic [5:0] OPC_ST_BYTE  = 6'h34;
  localparam logic [5:0] OPC_ST_HALF  = 6'h35;
  localparam logic [5:0] OPC_ST_WORD  = 6'h36;
  localparam logic [5:0] OPC_LDI_BYTE = 6'h38;
  localparam logic [5:0] OPC_LDI_HALF = 6'h39;

  // ****************************************
  // Field positions (vector bit = 31 - doc bit)
  // ****************************************
  localparam int UNC_DELAY_BIT  = 20;  // Doc bit 11
  localparam int UNC_ABS_BIT    = 19;  // Doc bit 12
  localparam int UNC_BRK_BIT    = 18;  // Doc bit 13
  localparam int COND_DELAY_BIT = 25;  // Doc bit 6
  localparam int SPR_DIR_BIT    = 14;  // 1 = move to special
  localparam int SPR_SEL_BIT    = 0;   // 0 = counter, 1 = status

  // Condition codes, low three bits of doc bits 6-10
  localparam logic [2:0] CND_ZERO   = 3'h0;
  localparam logic [2:0] CND_NZERO  = 3'h1;
  localparam logic [2:0] CND_NEG    = 3'h2;
  localparam logic [2:0] CND_NPOS   = 3'h3;
  localparam logic [2:0] CND_POS    = 3'h4;
  localparam logic [2:0] CND_NNEG   = 3'h5;

  // ****************************************
  // Status register bit positions and reset values
  // ****************************************
  localparam int MSR_BE_BIT  = 0;   // Doc bit 31
  localparam int MSR_IE_BIT  = 1;   // Doc bit 30
  localparam int MSR_C_BIT   = 2;   // Doc bit 29
  localparam int MSR_BIP_BIT = 3;   // Doc bit 28
  localparam int MSR_CC_BIT  = 31;  // Doc bit 0
  localparam logic        MSR_BIT_RESET = 1'b0;
  localparam logic [31:0] PC_RESET      = 32'h00000000;
  localparam logic [31:0] GPR_RESET     = 32'h00000000;
  localparam logic [31:0] INSTR_STEP    = 32'h00000004;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } bldsr_size_t;

  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_LOAD = 1'b1
  } bldsr_state_t;

endpackage
`default_nettype wire

// ===== bldsr_core.sv
/*
  Execute logic for immediate branches, register/immediate loads, register stores,
  and the architectural state: 32 general registers, program counter and
  machine status. Assumes instructions are presented in program order at the
  address on fetch_addr, data memory answers loads with mem_rvalid on this
  clock, and break pins are asynchronous to this clock.
*/
`timescale 1ns/10ps
`default_nettype none
module bldsr_core
  import bldsr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  output logic             instr_ready,
  output logic [31:0]      fetch_addr,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [1:0]       mem_size,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        carry_we,
  input  wire logic        carry_value,
  input  wire logic        hw_break_in,
  input  wire logic        external_nonmaskable_break_in,
  output logic             interrupt_enable_flag,
  output logic             bus_lock_enable,
  output logic             break_in_progress
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0]  rf_r [32];
  logic [31:0]  pc_r;
  logic         flush_r;
  logic         dslot_r;
  logic [31:0]  dslot_tgt_r;
  bldsr_state_t state_r;
  logic         ready_r;
  logic [4:0]   load_rd_r;
  bldsr_size_t  load_sz_r;
  logic         req_r;
  logic         we_r;
  logic [31:0]  addr_r;
  logic [1:0]   size_r;
  logic [31:0]  wdata_r;
  logic         be_r;
  logic         ie_r;
  logic         c_r;
  logic         bip_r;
  logic         mts_pend_r;
  logic [31:0]  mts_data_r;
  logic [1:0]   brk_s1_r;
  logic [1:0]   brk_s2_r;

  // ****************************************
  // Decode
  // ****************************************
  logic        take;
  logic        exec;
  logic [5:0]  opc;
  logic [4:0]  rd;
  logic [4:0]  ra;
  logic [4:0]  rb;
  logic [31:0] imm_s;
  logic [31:0] ra_val;
  logic [31:0] rb_val;
  logic [31:0] rd_val;
  logic [31:0] msr_rd;
  logic        is_unc;
  logic        is_cond;
  logic        is_brk;
  logic        cond_true;
  logic        br_taken;
  logic        br_delay;
  logic [31:0] br_tgt;
  logic        is_load;
  logic        is_store;
  logic        is_mfs;
  logic        mts_msr;
  bldsr_size_t ls_size;
  logic [31:0] ls_addr;

  // Zero register never holds anything but zero
  function automatic logic [31:0] rd_gpr(input logic [4:0] idx, input logic [31:0] val);
    rd_gpr = (idx == 5'h00) ? GPR_RESET : val;
  endfunction

  // Size-aligned address: halfword clears bit 0, word clears bits 1:0
  function automatic logic [31:0] align(input logic [31:0] a, input bldsr_size_t s);
    align = (s == SZ_WORD) ? {a[31:2], 2'b00} : (s == SZ_HALF) ? {a[31:1], 1'b0} : a;
  endfunction

  assign take    = instr_valid && ready_r && (state_r == ST_RUN);
  assign exec    = take && !flush_r;
  assign opc     = instr_word[31:26];
  assign rd      = instr_word[25:21];
  assign ra      = instr_word[20:16];
  assign rb      = instr_word[15:11];
  assign imm_s   = {{16{instr_word[15]}}, instr_word[15:0]};
  assign ra_val  = rd_gpr(ra, rf_r[ra]);
  assign rb_val  = rd_gpr(rb, rf_r[rb]);
  assign rd_val  = rd_gpr(rd, rf_r[rd]);
  // Carry copy mirrored, reserved bits zero
  assign msr_rd  = {c_r, 27'h0000000, bip_r, c_r, ie_r, be_r};
  assign is_unc  = (opc == OPC_UNCOND);
  assign is_cond = (opc == OPC_COND);
  assign is_brk  = is_unc && instr_word[UNC_BRK_BIT];
  assign is_mfs  = (opc == OPC_SPECIAL) && !instr_word[SPR_DIR_BIT];
  assign mts_msr = exec && (opc == OPC_SPECIAL) && instr_word[SPR_DIR_BIT] && instr_word[SPR_SEL_BIT];

  // Branch condition, target and slot handling
  always_comb
  begin
    unique case (instr_word[23:21])
      CND_ZERO:  cond_true = (ra_val == 32'h00000000);
      CND_NZERO: cond_true = (ra_val != 32'h00000000);
      CND_NEG:   cond_true = ra_val[31];
      CND_NPOS:  cond_true = ra_val[31] || (ra_val == 32'h00000000);
      CND_POS:   cond_true = !ra_val[31] && (ra_val != 32'h00000000);
      CND_NNEG:  cond_true = !ra_val[31];
      default:   cond_true = 1'b0;  // Codes 6 and 7 are undefined
    endcase
    br_taken = is_unc || (is_cond && !instr_word[24] && cond_true);
    br_delay = is_unc ? instr_word[UNC_DELAY_BIT] : instr_word[COND_DELAY_BIT];
    br_tgt   = (is_unc && (instr_word[UNC_ABS_BIT] || is_brk)) ? imm_s : pc_r + imm_s;
  end

  // Load/store decode, address and size
  always_comb
  begin
    is_load  = 1'b1;
    is_store = 1'b0;
    ls_size  = SZ_WORD;
    ls_addr  = ra_val + rb_val;
    unique case (opc)
      OPC_LD_BYTE:  ls_size = SZ_BYTE;
      OPC_LD_HALF:  ls_size = SZ_HALF;
      OPC_LD_WORD:  ls_size = SZ_WORD;
      OPC_LDI_BYTE:
      begin
        ls_size = SZ_BYTE;
        ls_addr = ra_val + imm_s;
      end
      OPC_LDI_HALF:
      begin
        ls_size = SZ_HALF;
        ls_addr = ra_val + imm_s;
      end
      OPC_ST_BYTE:
      begin
        is_load  = 1'b0;
        is_store = 1'b1;
        ls_size  = SZ_BYTE;
      end
      OPC_ST_HALF:
      begin
        is_load  = 1'b0;
        is_store = 1'b1;
        ls_size  = SZ_HALF;
      end
      OPC_ST_WORD:
      begin
        is_load  = 1'b0;
        is_store = 1'b1;
      end
      default: is_load = 1'b0;
    endcase
  end

  // ****************************************
  // General register file
  // ****************************************
  // Link, move-from-special and load return share one write port; a load
  // stalls the instruction port so they never collide.
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 32; i++)
        rf_r[i] <= GPR_RESET;
    end
    else if (state_r == ST_LOAD && mem_rvalid && load_rd_r != 5'h00)
    begin
      unique case (load_sz_r)
        SZ_BYTE: rf_r[load_rd_r] <= {24'h000000, mem_rdata[7:0]};
        SZ_HALF: rf_r[load_rd_r] <= {16'h0000, mem_rdata[15:0]};
        SZ_WORD: rf_r[load_rd_r] <= mem_rdata;
        default: rf_r[load_rd_r] <= mem_rdata;
      endcase
    end
    else if (exec && rd != 5'h00 && is_unc)
      rf_r[rd] <= pc_r;
    else if (exec && rd != 5'h00 && is_mfs)
      rf_r[rd] <= instr_word[SPR_SEL_BIT] ? msr_rd : pc_r;
  end

  // ****************************************
  // Program counter and delay slot
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pc_r        <= PC_RESET;
      flush_r     <= 1'b0;
      dslot_r     <= 1'b0;
      dslot_tgt_r <= PC_RESET;
    end
    else if (exec && br_taken && br_delay)
    begin
      dslot_r     <= 1'b1;
      dslot_tgt_r <= br_tgt;
      pc_r        <= pc_r + INSTR_STEP;
    end
    else if (exec && br_taken)
    begin
      pc_r    <= br_tgt;
      flush_r <= 1'b1;
    end
    else if (exec && dslot_r)
    begin
      pc_r    <= dslot_tgt_r;
      dslot_r <= 1'b0;
    end
    else if (exec)
      pc_r <= pc_r + INSTR_STEP;
    else if (take)
      flush_r <= 1'b0;  // Wrong-path word dropped, counter holds
  end

  // ****************************************
  // Data memory requests
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_r   <= ST_RUN;
      ready_r   <= 1'b1;
      load_rd_r <= 5'h00;
      load_sz_r <= SZ_WORD;
      req_r     <= 1'b0;
      we_r      <= 1'b0;
      addr_r    <= 32'h00000000;
      size_r    <= SZ_WORD;
      wdata_r   <= 32'h00000000;
    end
    else
    begin
      req_r <= exec && (is_load || is_store);
      we_r  <= exec && is_store;
      if (exec && (is_load || is_store))
      begin
        addr_r  <= align(ls_addr, ls_size);
        size_r  <= ls_size;
        wdata_r <= (ls_size == SZ_BYTE) ? {24'h000000, rd_val[7:0]} :
                   (ls_size == SZ_HALF) ? {16'h0000, rd_val[15:0]} : rd_val;
      end
      if (exec && is_load)
      begin
        state_r   <= ST_LOAD;
        ready_r   <= 1'b0;
        load_rd_r <= rd;
        load_sz_r <= ls_size;
      end
      else if (state_r == ST_LOAD && mem_rvalid)
      begin
        state_r <= ST_RUN;
        ready_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Break pin synchronisers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      brk_s1_r <= 2'b00;
      brk_s2_r <= 2'b00;
    end
    else
    begin
      brk_s1_r <= {external_nonmaskable_break_in, hw_break_in};
      brk_s2_r <= brk_s1_r;
    end
  end

  // ****************************************
  // Machine status
  // ****************************************
  // Writes are staged one cycle; break sets win over a clearing write
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      mts_pend_r <= 1'b0;
      mts_data_r <= 32'h00000000;
      be_r       <= MSR_BIT_RESET;
      ie_r       <= MSR_BIT_RESET;
      c_r        <= MSR_BIT_RESET;
      bip_r      <= MSR_BIT_RESET;
    end
    else
    begin
      mts_pend_r <= mts_msr;
      mts_data_r <= ra_val;
      if (mts_pend_r)
      begin
        be_r <= mts_data_r[MSR_BE_BIT];
        ie_r <= mts_data_r[MSR_IE_BIT];
      end
      if (carry_we)
        c_r <= carry_value;
      else if (mts_pend_r)
        c_r <= mts_data_r[MSR_C_BIT];
      if ((exec && is_brk) || (|brk_s2_r))
        bip_r <= 1'b1;
      else if (mts_pend_r)
        bip_r <= mts_data_r[MSR_BIP_BIT];
    end
  end

  assign instr_ready           = ready_r;
  assign fetch_addr            = pc_r;
  assign mem_req               = req_r;
  assign mem_we                = we_r;
  assign mem_addr              = addr_r;
  assign mem_size              = size_r;
  assign mem_wdata             = wdata_r;
  assign interrupt_enable_flag = ie_r;
  assign bus_lock_enable       = be_r;
  assign break_in_progress     = bip_r;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_mts_issue;
    mts_msr;
  endsequence
  sequence s_mts_applied;
    mts_pend_r ##1 (ie_r == $past(mts_data_r[MSR_IE_BIT]));
  endsequence

  a_zero_reg_held: assert property (@(posedge clock) disable iff (!resetn) rf_r[0] == 32'h0)
    else $error("register zero not zero");
  a_mts_not_early: assert property (@(posedge clock) disable iff (!resetn)
    s_mts_issue |=> (ie_r == $past(ie_r)) ##0 s_mts_applied)
    else $error("status write timing wrong");
  a_brk_sets_bip: assert property (@(posedge clock) disable iff (!resetn)
    (exec && is_brk) |=> bip_r && pc_r == $past(imm_s))
    else $error("software break wrong");
  a_pin_sets_bip: assert property (@(posedge clock) disable iff (!resetn)
    $rose(external_nonmaskable_break_in) |-> ##3 bip_r)
    else $error("break pin did not set flag");
  a_nodelay_flush: assert property (@(posedge clock) disable iff (!resetn)
    (exec && br_taken && !br_delay) |=> flush_r && pc_r == $past(br_tgt))
    else $error("non-delayed branch wrong");
  a_delay_slot_run: assert property (@(posedge clock) disable iff (!resetn)
    (exec && br_taken && br_delay) |=> dslot_r && !flush_r && pc_r == $past(pc_r) + INSTR_STEP)
    else $error("delayed branch wrong");
  a_load_addr_ok: assert property (@(posedge clock) disable iff (!resetn)
    (exec && opc == OPC_LD_WORD) |=> mem_req && !mem_we && mem_addr[1:0] == 2'b00
    && mem_addr[31:2] == $past(ls_addr[31:2]))
    else $error("load address wrong");
  a_store_half_ok: assert property (@(posedge clock) disable iff (!resetn)
    (exec && opc == OPC_ST_HALF) |=> mem_we && mem_wdata == {16'h0000, $past(rd_val[15:0])})
    else $error("store data wrong");
  a_ld_byte_zext: assert property (@(posedge clock) disable iff (!resetn)
    (state_r == ST_LOAD && mem_rvalid && load_sz_r == SZ_BYTE && load_rd_r != 5'h00)
    |=> rf_r[$past(load_rd_r)] == {24'h000000, $past(mem_rdata[7:0])} && instr_ready)
    else $error("byte load not zero-extended");
  a_msr_reserved: assert property (@(posedge clock) disable iff (!resetn)
    msr_rd[30:4] == 27'h0 && msr_rd[MSR_CC_BIT] == c_r)
    else $error("status read image wrong");

endmodule
`default_nettype wire

// ===== test_branch_loadstore_decode_state_regs.sv
/*
  Self-checking bench for bldsr_core: a reference model of registers, counter
  and status flags is compared with the core at every result.
  Assumes bldsr_pkg is compiled first and one 100 MHz clock drives the core.
*/
`timescale 1ns/10ps
`default_nettype none
module test_branch_loadstore_decode_state_regs
  import bldsr_pkg::*;
;
  `define CHK(what, exp, got) \
    begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); end end

  // ****************************************
  // Signals and model state
  // ****************************************
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h00000000;
  logic        mem_rvalid = 1'b0;
  logic [31:0] mem_rdata = 32'h00000000;
  logic        carry_we = 1'b0;
  logic        carry_value = 1'b0;
  logic        hw_break_in = 1'b0;
  logic        external_nonmaskable_break_in = 1'b0;
  logic        instr_ready, mem_req, mem_we, interrupt_enable_flag, bus_lock_enable, break_in_progress;
  logic [31:0] fetch_addr, mem_addr, mem_wdata;
  logic [1:0]  mem_size;
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [31:0] lfsr_r = 32'h972A74CE;
  logic [31:0] gpr_m [32];
  logic [31:0] pc_m, tgt_m;
  logic        skip_m, pend_m, be_m, ie_m, c_m, bip_m;
  logic [31:0] val_q [$];
  logic [5:0]  mo [8] = '{OPC_LD_BYTE, OPC_LD_HALF, OPC_LD_WORD, OPC_LDI_BYTE, OPC_LDI_HALF,
                          OPC_ST_BYTE, OPC_ST_HALF, OPC_ST_WORD};
  logic [4:0]  uc [5] = '{5'h10, 5'h08, 5'h18, 5'h00, 5'h0C};

  bldsr_core bldsr_core_inst (
    .clock                         (clock),
    .resetn                        (resetn),
    .instr_valid                   (instr_valid),
    .instr_word                    (instr_word),
    .instr_ready                   (instr_ready),
    .fetch_addr                    (fetch_addr),
    .mem_req                       (mem_req),
    .mem_we                        (mem_we),
    .mem_addr                      (mem_addr),
    .mem_size                      (mem_size),
    .mem_wdata                     (mem_wdata),
    .mem_rvalid                    (mem_rvalid),
    .mem_rdata                     (mem_rdata),
    .carry_we                      (carry_we),
    .carry_value                   (carry_value),
    .hw_break_in                   (hw_break_in),
    .external_nonmaskable_break_in (external_nonmaskable_break_in),
    .interrupt_enable_flag         (interrupt_enable_flag),
    .bus_lock_enable               (bus_lock_enable),
    .break_in_progress             (break_in_progress)
  );

  // ****************************************
  // Clock, hang guard and helpers
  // ****************************************
  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  // Cut a hang short well past the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] tb(input logic [5:0] op, input logic [4:0] d, a, input logic [15:0] i);
    return {op, d, a, i};
  endfunction

  // Status as the move-from-special read shows it
  function automatic logic [31:0] msr_m();
    return {c_m, 27'h0000000, bip_m, c_m, ie_m, be_m};
  endfunction

  task automatic wr(input logic [4:0] r, input logic [31:0] v);
    if (r != 5'h00)
      gpr_m[r] = v;
  endtask

  task automatic chk_flags();
    `CHK("bus lock", be_m, bus_lock_enable)
    `CHK("int enable", ie_m, interrupt_enable_flag)
    `CHK("break flag", bip_m, break_in_progress)
  endtask

  // ****************************************
  // One instruction: drive, model, compare
  // ****************************************
  task automatic exec(input logic [31:0] w);
    logic [5:0]  op;
    logic [4:0]  rd;
    logic [31:0] imm, a, adr, d, mk;
    logic [1:0]  sz;
    logic        tk, p;
    int          n;
    op = w[31:26];
    rd = w[25:21];
    imm = {{16{w[15]}}, w[15:0]};
    a = gpr_m[w[20:16]];
    sz = op[1:0];
    mk = (sz == 2'b00) ? 32'h000000FF : (sz == 2'b01) ? 32'h0000FFFF : 32'hFFFFFFFF;
    adr = op[3] ? a + imm : a + gpr_m[w[15:11]];
    p = pend_m;
    pend_m = 1'b0;
    // Idle edge first, so valid never falls and rises in one time step
    @(posedge clock);
    #1;
    instr_valid = 1'b1;
    instr_word = w;
    n = 0;
    while (instr_ready !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    instr_valid = 1'b0;
    if (skip_m)
    begin
      skip_m = 1'b0;
      `CHK("discard req", 1'b0, mem_req)
      `CHK("discard pc", pc_m, fetch_addr)
      return;
    end
    case (op)
      OPC_UNCOND:
      begin
        wr(rd, pc_m);
        tgt_m = (w[19] | w[18]) ? imm : pc_m + imm;
        if (w[18])
          bip_m = 1'b1;
        pend_m = w[20];
        skip_m = !w[20];
        pc_m = w[20] ? pc_m + 32'h00000004 : tgt_m;
      end
      OPC_COND:
      begin
        case (rd[2:0])
          CND_ZERO:  tk = (a == 32'h00000000);
          CND_NZERO: tk = (a != 32'h00000000);
          CND_NEG:   tk = a[31];
          CND_NPOS:  tk = a[31] || a == 32'h00000000;
          CND_POS:   tk = !a[31] && a != 32'h00000000;
          default:   tk = !a[31];
        endcase
        tgt_m = pc_m + imm;
        pend_m = tk && rd[4];
        skip_m = tk && !rd[4];
        pc_m = skip_m ? tgt_m : pc_m + 32'h00000004;
      end
      OPC_SPECIAL:
      begin
        if (!w[14])
          wr(rd, w[0] ? msr_m() : pc_m);
        pc_m = pc_m + 32'h00000004;
        if (w[14] && w[0])
        begin
          // Staged write: flags still old right after the take edge
          chk_flags();
          {bip_m, c_m, ie_m, be_m} = a[3:0];
          @(posedge clock);
          #1;
        end
      end
      OPC_LD_BYTE, OPC_LD_HALF, OPC_LD_WORD, OPC_LDI_BYTE, OPC_LDI_HALF, OPC_ST_BYTE, OPC_ST_HALF, OPC_ST_WORD:
      begin
        `CHK("mem req", 1'b1, mem_req)
        `CHK("mem we", op[2], mem_we)
        `CHK("mem addr", adr & ~{30'h00000000, sz[1], |sz}, mem_addr)
        `CHK("mem size", sz, mem_size)
        if (op[2])
          `CHK("store data", gpr_m[rd] & mk, mem_wdata & mk)
        else
        begin
          `CHK("ready low", 1'b0, instr_ready)
          lfsr_r = lfsr_next(lfsr_r);
          d = (val_q.size() > 0) ? val_q.pop_front() : lfsr_r;
          repeat (1 + lfsr_r[1:0]) @(posedge clock);
          #1;
          mem_rvalid = 1'b1;
          mem_rdata = d;
          @(posedge clock);
          #1;
          mem_rvalid = 1'b0;
          mem_rdata = ~d;
          `CHK("ready back", 1'b1, instr_ready)
          wr(rd, d & mk);
        end
        pc_m = pc_m + 32'h00000004;
      end
      default: pc_m = pc_m + 32'h00000004;
    endcase
    if (p)
      pc_m = tgt_m;
    `CHK("fetch addr", pc_m, fetch_addr)
    chk_flags();
  endtask

  task automatic probe(input logic [4:0] r);
    exec(tb(OPC_ST_WORD, r, 5'h00, 16'h0000));
  endtask

  task automatic pin_break(input int k);
    if (k == 0)
      hw_break_in = 1'b1;
    else
      external_nonmaskable_break_in = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk_flags();
    @(posedge clock);
    #1;
    hw_break_in = 1'b0;
    external_nonmaskable_break_in = 1'b0;
    bip_m = 1'b1;
    chk_flags();
    exec(tb(OPC_SPECIAL, 5'h00, 5'h00, 16'hC001));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    foreach (gpr_m[i])
      gpr_m[i] = GPR_RESET;
    {pc_m, tgt_m, skip_m, pend_m, be_m, ie_m, c_m, bip_m} = '0;
    repeat (4) @(posedge clock);
    #1;
    `CHK("reset pc", PC_RESET, fetch_addr)
    `CHK("reset size", 2'b10, mem_size)
    chk_flags();
    resetn = 1'b1;
    for (int r = 0; r < 32; r++)
      probe(r[4:0]);
    $display("test reset values done");
    for (int r = 0; r < 32; r++)
      exec(tb(OPC_LD_WORD, r[4:0], 5'h00, 16'h0000));
    for (int r = 0; r < 32; r++)
      probe(r[4:0]);
    $display("test register file done");
    for (int i = 0; i < 24; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      exec({mo[i % 8], lfsr_r[25:0]});
      probe(lfsr_r[25:21]);
    end
    $display("test loads and stores done");
    for (int i = 0; i < 10; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      exec(tb(OPC_UNCOND, lfsr_r[20:16], uc[i % 5], {lfsr_r[15:2], 2'b00}));
      probe(5'h01);
      probe(lfsr_r[20:16]);
      exec(tb(OPC_SPECIAL, 5'h00, 5'h00, 16'hC001));
    end
    $display("test jumps done");
    for (int c = 0; c < 12; c++)
      for (int k = 0; k < 3; k++)
      begin
        lfsr_r = lfsr_next(lfsr_r);
        val_q.push_back(k == 0 ? 32'h00000000 : k == 1 ? lfsr_r | 32'h80000000 : {1'b0, lfsr_r[31:1]} | 32'h1);
        exec(tb(OPC_LD_WORD, 5'h03, 5'h00, 16'h0000));
        exec(tb(OPC_COND, {c >= 6, 1'b0, 3'(c % 6)}, 5'h03, {lfsr_r[15:2], 2'b00}));
        probe(5'h01);
      end
    $display("test conditional branches done");
    for (int v = 0; v < 2; v++)
    begin
      carry_we = 1'b1;
      carry_value = !v;
      @(posedge clock);
      #1;
      carry_we = 1'b0;
      c_m = !v;
      val_q.push_back(v == 0 ? 32'hFFFFFFFF : 32'h0FFFFFF2);
      exec(tb(OPC_LD_WORD, 5'h04, 5'h00, 16'h0000));
      exec(tb(OPC_SPECIAL, 5'h00, 5'h04, 16'hC001));
      exec(tb(OPC_SPECIAL, 5'h05, 5'h00, 16'h8001));
      probe(5'h05);
      exec(tb(OPC_SPECIAL, 5'h00, 5'h04, 16'hC000));
      exec(tb(OPC_SPECIAL, 5'h06, 5'h00, 16'h8000));
      probe(5'h06);
    end
    exec(tb(OPC_SPECIAL, 5'h00, 5'h00, 16'hC001));
    $display("test status and counter done");
    pin_break(0);
    pin_break(1);
    $display("test break inputs done");
    print_verdict();
  end

endmodule
`default_nettype wire
